/* File: rtl/rcv_pkg.sv */
package rcv_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] VALUE_OFFSET  = 12'h004;
  localparam logic [11:0] ALARM_OFFSET  = 12'h008;

  // Control register fields
  localparam int COUNT_EN_BIT  = 0;
  localparam int WR_EN_BIT     = 1;
  localparam int HALF_SEC_BIT  = 2;
  localparam int VPTR_LSB      = 8;
  localparam int APTR_LSB      = 10;

  // Control reset values
  localparam logic       COUNT_EN_RST = 1'b0;
  localparam logic       WR_EN_RST    = 1'b0;
  localparam logic [1:0] PTR_RST      = 2'h0;

  // Digit field positions inside a 16-bit value word
  localparam int YEAR_TENS_LSB  = 4;
  localparam int YEAR_ONES_LSB  = 0;
  localparam int MONTH_TENS_BIT = 12;
  localparam int MONTH_ONES_LSB = 8;
  localparam int DAY_TENS_LSB   = 4;
  localparam int DAY_ONES_LSB   = 0;
  localparam int WEEKDAY_LSB    = 8;
  localparam int HOUR_TENS_LSB  = 4;
  localparam int HOUR_ONES_LSB  = 0;
  localparam int MIN_TENS_LSB   = 12;
  localparam int MIN_ONES_LSB   = 8;
  localparam int SEC_TENS_LSB   = 4;
  localparam int SEC_ONES_LSB   = 0;

  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int HALF_SEC_NS         = 500_000_000;
  localparam int HALF_SEC_CYCLES_DEF = HALF_SEC_NS / CLK_PERIOD_NS;

  // Window pointer selections
  typedef enum logic [1:0] {
    WIN_MIN_SEC      = 2'b00,
    WIN_WEEKDAY_HOUR = 2'b01,
    WIN_MONTH_DAY    = 2'b10,
    WIN_YEAR         = 2'b11
  } rcv_win_e;

  // Calendar value digits
  typedef struct packed {
    logic [3:0] yearTens;
    logic [3:0] yearOnes;
    logic       monthTens;
    logic [3:0] monthOnes;
    logic [1:0] dayTens;
    logic [3:0] dayOnes;
    logic [2:0] weekday;
    logic [1:0] hourTens;
    logic [3:0] hourOnes;
    logic [2:0] minTens;
    logic [3:0] minOnes;
    logic [2:0] secTens;
    logic [3:0] secOnes;
  } rcv_time_s;

endpackage

/* File: rtl/rcv_calendar_regs.sv */
`timescale 1ns/10ps
// Operation
// - Year tens in 7:4, ones in 3:0
// - Year writes need value write enable
// - Month tens bit 12, ones 11:8
// - Day tens 5:4, ones 3:0
// - Date, weekday/hour and alarm writes gated
// - Weekday three bits 10:8, 0 to 6
// - Hour tens 5:4, ones 3:0
// - Minute tens 14:12, ones 11:8
// - Second tens 6:4, ones 3:0
// - Unused bits read zero, writes ignored
// - Digit fields have no reset value
// - Alarm registers mirror timekeeping layouts except year, whose window reads zero
// - Window pointer decrements to zero on reads and upper-byte writes
// - Value window writes blocked when disabled
// - Seconds byte write clears half-second flag
module rcv_calendar_regs
  import rcv_pkg::*;
#(
  parameter int ADDR_W          = 12,
  parameter int HALF_SEC_CYCLES = HALF_SEC_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Calendar state towards counting and alarm logic
  output rcv_time_s              timeNow,
  output rcv_time_s              alarmValue,
  output logic                   halfSecondFlag,
  output logic                   secondTick
);

  localparam int CW = $clog2(HALF_SEC_CYCLES + 1);

  function automatic logic [15:0] packWord(input rcv_time_s t, input rcv_win_e idx, input logic isAlarm);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      WIN_MIN_SEC: begin
        w[MIN_TENS_LSB +: 3] = t.minTens;
        w[MIN_ONES_LSB +: 4] = t.minOnes;
        w[SEC_TENS_LSB +: 3] = t.secTens;
        w[SEC_ONES_LSB +: 4] = t.secOnes;
      end
      WIN_WEEKDAY_HOUR: begin
        w[WEEKDAY_LSB +: 3]   = t.weekday;
        w[HOUR_TENS_LSB +: 2] = t.hourTens;
        w[HOUR_ONES_LSB +: 4] = t.hourOnes;
      end
      WIN_MONTH_DAY: begin
        w[MONTH_TENS_BIT]      = t.monthTens;
        w[MONTH_ONES_LSB +: 4] = t.monthOnes;
        w[DAY_TENS_LSB +: 2]   = t.dayTens;
        w[DAY_ONES_LSB +: 4]   = t.dayOnes;
      end
      default: begin
        if (!isAlarm) begin
          w[YEAR_TENS_LSB +: 4] = t.yearTens;
          w[YEAR_ONES_LSB +: 4] = t.yearOnes;
        end
      end
    endcase
    return w;
  endfunction

  function automatic rcv_time_s storeWord(input rcv_time_s t, input rcv_win_e idx, input logic isAlarm,
                                          input logic [15:0] data, input logic [1:0] strb);
    rcv_time_s   n;
    logic [15:0] cur;
    logic [15:0] w;
    n   = t;
    cur = packWord(t, idx, isAlarm);
    w   = {strb[1] ? data[15:8] : cur[15:8], strb[0] ? data[7:0] : cur[7:0]};
    // Only digit positions are picked up, so unused bits are dropped
    case (idx)
      WIN_MIN_SEC: begin
        n.minTens = w[MIN_TENS_LSB +: 3];
        n.minOnes = w[MIN_ONES_LSB +: 4];
        n.secTens = w[SEC_TENS_LSB +: 3];
        n.secOnes = w[SEC_ONES_LSB +: 4];
      end
      WIN_WEEKDAY_HOUR: begin
        n.weekday  = w[WEEKDAY_LSB +: 3];
        n.hourTens = w[HOUR_TENS_LSB +: 2];
        n.hourOnes = w[HOUR_ONES_LSB +: 4];
      end
      WIN_MONTH_DAY: begin
        n.monthTens = w[MONTH_TENS_BIT];
        n.monthOnes = w[MONTH_ONES_LSB +: 4];
        n.dayTens   = w[DAY_TENS_LSB +: 2];
        n.dayOnes   = w[DAY_ONES_LSB +: 4];
      end
      default: begin
        if (!isAlarm) begin
          n.yearTens = w[YEAR_TENS_LSB +: 4];
          n.yearOnes = w[YEAR_ONES_LSB +: 4];
        end
      end
    endcase
    return n;
  endfunction

  function automatic logic [7:0] lastDay(input rcv_time_s t);
    logic       leap;
    logic [7:0] month;
    leap  = t.yearTens[0] ? (t.yearOnes == 4'h2 || t.yearOnes == 4'h6)
                          : (t.yearOnes == 4'h0 || t.yearOnes == 4'h4 || t.yearOnes == 4'h8);
    month = {3'h0, t.monthTens, t.monthOnes};
    if (month == 8'h02) begin
      lastDay = leap ? 8'h29 : 8'h28;
    end else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11) begin
      lastDay = 8'h30;
    end else begin
      lastDay = 8'h31;
    end
  endfunction

  function automatic rcv_time_s tickTime(input rcv_time_s t);
    rcv_time_s n;
    n = t;
    if (t.secOnes != 4'h9) begin
      n.secOnes = t.secOnes + 4'h1;
    end else begin
      n.secOnes = 4'h0;
      if (t.secTens != 3'h5) begin
        n.secTens = t.secTens + 3'h1;
      end else begin
        n.secTens = 3'h0;
        if (t.minOnes != 4'h9) begin
          n.minOnes = t.minOnes + 4'h1;
        end else begin
          n.minOnes = 4'h0;
          if (t.minTens != 3'h5) begin
            n.minTens = t.minTens + 3'h1;
          end else begin
            n.minTens = 3'h0;
            if ({t.hourTens, t.hourOnes} == 6'h23) begin
              n.hourTens = 2'h0;
              n.hourOnes = 4'h0;
              n.weekday  = (t.weekday == 3'h6) ? 3'h0 : t.weekday + 3'h1;
              if ({2'h0, t.dayTens, t.dayOnes} == lastDay(t)) begin
                n.dayTens = 2'h0;
                n.dayOnes = 4'h1;
                if ({t.monthTens, t.monthOnes} == 5'h12) begin
                  n.monthTens = 1'b0;
                  n.monthOnes = 4'h1;
                  if ({t.yearTens, t.yearOnes} == 8'h99) begin
                    n.yearTens = 4'h0;
                    n.yearOnes = 4'h0;
                  end else if (t.yearOnes == 4'h9) begin
                    n.yearOnes = 4'h0;
                    n.yearTens = t.yearTens + 4'h1;
                  end else begin
                    n.yearOnes = t.yearOnes + 4'h1;
                  end
                end else if (t.monthOnes == 4'h9) begin
                  n.monthOnes = 4'h0;
                  n.monthTens = 1'b1;
                end else begin
                  n.monthOnes = t.monthOnes + 4'h1;
                end
              end else if (t.dayOnes == 4'h9) begin
                n.dayOnes = 4'h0;
                n.dayTens = t.dayTens + 2'h1;
              end else begin
                n.dayOnes = t.dayOnes + 4'h1;
              end
            end else if (t.hourOnes == 4'h9) begin
              n.hourOnes = 4'h0;
              n.hourTens = t.hourTens + 2'h1;
            end else begin
              n.hourOnes = t.hourOnes + 4'h1;
            end
          end
        end
      end
    end
    return n;
  endfunction

  logic          countEnable_r;
  logic          valueWriteEnable_r;
  rcv_win_e      valuePtr_r;
  rcv_win_e      alarmPtr_r;
  logic [CW-1:0] halfCnt_r;
  logic          access;
  logic          done;
  logic          hitCtrl;
  logic          hitValue;
  logic          hitAlarm;
  logic          valueWr;
  logic          alarmWr;
  logic          secLowWr;
  logic [31:0]   readWord;

  assign access   = psel & penable;
  assign done     = access & pready;
  assign valueWr  = done & pwrite & hitValue & valueWriteEnable_r;
  assign alarmWr  = done & pwrite & hitAlarm & valueWriteEnable_r;
  assign secLowWr = valueWr & pstrb[0] & (valuePtr_r == WIN_MIN_SEC);

  // Address decode
  always_comb begin
    hitCtrl  = 1'b0;
    hitValue = 1'b0;
    hitAlarm = 1'b0;
    if (paddr == ADDR_W'(CTRL_OFFSET)) begin
      hitCtrl = 1'b1;
    end else if (paddr == ADDR_W'(VALUE_OFFSET)) begin
      hitValue = 1'b1;
    end else if (paddr == ADDR_W'(ALARM_OFFSET)) begin
      hitAlarm = 1'b1;
    end
  end

  // Read mux
  always_comb begin
    readWord = 32'h0000_0000;
    if (hitCtrl) begin
      readWord[COUNT_EN_BIT]    = countEnable_r;
      readWord[WR_EN_BIT]       = valueWriteEnable_r;
      readWord[HALF_SEC_BIT]    = halfSecondFlag;
      readWord[VPTR_LSB +: 2]   = valuePtr_r;
      readWord[APTR_LSB +: 2]   = alarmPtr_r;
    end else if (hitValue) begin
      readWord[15:0] = packWord(timeNow, valuePtr_r, 1'b0);
    end else if (hitAlarm) begin
      readWord[15:0] = packWord(alarmValue, alarmPtr_r, 1'b1);
    end
  end

  // APB answer: one wait state, data and error set with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~(hitCtrl | hitValue | hitAlarm);
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : readWord;
      end
    end
  end

  // Control bits
  always_ff @(posedge clk) begin
    if (rst) begin
      countEnable_r      <= COUNT_EN_RST;
      valueWriteEnable_r <= WR_EN_RST;
    end else if (done & pwrite & hitCtrl & pstrb[0]) begin
      countEnable_r      <= pwdata[COUNT_EN_BIT];
      valueWriteEnable_r <= pwdata[WR_EN_BIT];
    end
  end

  // Window pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      valuePtr_r <= rcv_win_e'(PTR_RST);
      alarmPtr_r <= rcv_win_e'(PTR_RST);
    end else if (done & pwrite & hitCtrl & pstrb[1]) begin
      valuePtr_r <= rcv_win_e'(pwdata[VPTR_LSB +: 2]);
      alarmPtr_r <= rcv_win_e'(pwdata[APTR_LSB +: 2]);
    end else if (done & (~pwrite | pstrb[1])) begin
      if (hitValue && valuePtr_r != WIN_MIN_SEC) begin
        valuePtr_r <= rcv_win_e'(valuePtr_r - 2'h1);
      end
      if (hitAlarm && alarmPtr_r != WIN_MIN_SEC) begin
        alarmPtr_r <= rcv_win_e'(alarmPtr_r - 2'h1);
      end
    end
  end

  // Half-second divider and seconds tick
  always_ff @(posedge clk) begin
    if (rst) begin
      halfCnt_r      <= '0;
      halfSecondFlag <= 1'b0;
      secondTick     <= 1'b0;
    end else begin
      secondTick <= 1'b0;
      if (secLowWr) begin
        halfCnt_r      <= '0;
        halfSecondFlag <= 1'b0;
      end else if (countEnable_r) begin
        if (halfCnt_r == CW'(HALF_SEC_CYCLES - 1)) begin
          halfCnt_r      <= '0;
          halfSecondFlag <= ~halfSecondFlag;
          secondTick     <= halfSecondFlag;
        end else begin
          halfCnt_r <= halfCnt_r + CW'(1);
        end
      end
    end
  end

  // Time value, no reset on digit fields
  always_ff @(posedge clk) begin
    if (valueWr) begin
      timeNow <= storeWord(timeNow, valuePtr_r, 1'b0, pwdata[15:0], pstrb[1:0]);
    end else if (secondTick) begin
      timeNow <= tickTime(timeNow);
    end
  end

  // Alarm value, no reset on digit fields
  always_ff @(posedge clk) begin
    if (alarmWr) begin
      alarmValue <= storeWord(alarmValue, alarmPtr_r, 1'b1, pwdata[15:0], pstrb[1:0]);
    end
  end

endmodule

/* File: tb/rcv_calendar_regs_chk.sv */
`timescale 1ns/10ps
module rcv_calendar_regs_chk
  import rcv_pkg::*;
#(
  parameter int ADDR_W          = 12,
  parameter int HALF_SEC_CYCLES = 4
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Calendar state
  input wire rcv_time_s         timeNow,
  input wire rcv_time_s         alarmValue,
  input wire logic              halfSecondFlag,
  input wire logic              secondTick
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic wrEn_r;
  logic done;
  assign done = psel && penable && pready && !pslverr;

  // Shadow of the value write enable
  always_ff @(posedge clk) begin
    if (rst)
      wrEn_r <= 1'b0;
    else if (done && pwrite && paddr == CTRL_OFFSET && pstrb[0])
      wrEn_r <= pwdata[WR_EN_BIT];
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence

  property p_answer;
    s_setup ##1 s_wait |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0000_0000;
  endproperty
  property p_upper;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_unused;
    done && !pwrite && (paddr == VALUE_OFFSET || paddr == ALARM_OFFSET) |->
      !prdata[15] && (!prdata[7] || prdata[15:8] == 8'h00);
  endproperty
  property p_tick;
    secondTick |=> !secondTick [*3];
  endproperty
  property p_lock_val;
    done && pwrite && paddr == VALUE_OFFSET && !wrEn_r && !secondTick |=> $stable(timeNow);
  endproperty
  property p_lock_alm;
    done && pwrite && paddr == ALARM_OFFSET && !wrEn_r |=> $stable(alarmValue[33:0]);
  endproperty

  a_answer: assert property (p_answer) else $error("no answer after one wait state");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  a_unused: assert property (p_unused) else $error("unused window bit set");
  a_tick: assert property (p_tick) else $error("second tick too close");
  a_lock_val: assert property (p_lock_val) else $error("locked value write took effect");
  a_lock_alm: assert property (p_lock_alm) else $error("locked alarm write took effect");
endmodule

/* File: tb/test_rcv_calendar_regs.sv */
`timescale 1ns/10ps
module test_rcv_calendar_regs;
  import rcv_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        halfSecondFlag;
  logic        secondTick;
  rcv_time_s   timeNow;
  rcv_time_s   alarmValue;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [15:0] wv [4] = '{16'hD9D9, 16'hFEE3, 16'hF2F1, 16'hFF99};
  logic [15:0] ev [4] = '{16'h5959, 16'h0623, 16'h1231, 16'h0099};

  rcv_calendar_regs #(.HALF_SEC_CYCLES(4)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timeNow(timeNow), .alarmValue(alarmValue), .halfSecondFlag(halfSecondFlag), .secondTick(secondTick));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b1, CTRL_OFFSET, 32'h0000_0F02, 4'h3);
    for (int p = 3; p >= 0; p--) begin
      acc(1'b1, VALUE_OFFSET, {16'h0000, wv[p]}, 4'h3);
      acc(1'b1, ALARM_OFFSET, {16'h0000, wv[p]}, 4'h3);
    end
    acc(1'b1, CTRL_OFFSET, 32'h0000_0F00, 4'h3);
    for (int p = 3; p >= 0; p--) begin
      acc(1'b1, VALUE_OFFSET, 32'h0000_0000, 4'h3);
      acc(1'b1, ALARM_OFFSET, 32'h0000_0000, 4'h3);
    end
    acc(1'b1, CTRL_OFFSET, 32'h0000_0F00, 4'h3);
    for (int p = 3; p >= 0; p--) begin
      acc(1'b0, VALUE_OFFSET, 32'h0000_0000, 4'h0);
      chk("value window", {16'h0000, ev[p]}, rd);
      acc(1'b0, ALARM_OFFSET, 32'h0000_0000, 4'h0);
      chk("alarm window", (p == 3) ? 32'h0000_0000 : {16'h0000, ev[p]}, rd);
    end
    acc(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
    chk("ctrl", 32'h0000_0000, rd);
    chk("timeNow", {4'h9, 4'h9, 1'h1, 4'h2, 2'h3, 4'h1, 3'h6, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h9}, timeNow);
    chk("alarmValue", {1'h1, 4'h2, 2'h3, 4'h1, 3'h6, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h9}, alarmValue[33:0]);
    acc(1'b0, 12'h00C, 32'h0000_0000, 4'h0);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0000_0000, rd);
    acc(1'b1, CTRL_OFFSET, 32'h0000_0001, 4'h1);
    while (secondTick !== 1'b1) @(posedge clk);
    acc(1'b1, CTRL_OFFSET, 32'h0000_0000, 4'h1);
    chk("rollover", {4'h0, 4'h0, 1'h0, 4'h1, 2'h0, 4'h1, 3'h0, 2'h0, 4'h0, 3'h0, 4'h0, 3'h0, 4'h0}, timeNow);
    acc(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
    chk("ctrl half set", 32'h0000_0004, rd);
    acc(1'b1, CTRL_OFFSET, 32'h0000_0002, 4'h1);
    acc(1'b1, VALUE_OFFSET, 32'h0000_0000, 4'h2);
    chk("half flag kept", 1'b1, halfSecondFlag);
    acc(1'b1, VALUE_OFFSET, 32'h0000_0000, 4'h1);
    chk("half flag cleared", 1'b0, halfSecondFlag);
    acc(1'b0, CTRL_OFFSET, 32'h0000_0000, 4'h0);
    chk("ctrl half clear", 32'h0000_0002, rd);
    tally_and_finish();
  end
endmodule

bind rcv_calendar_regs rcv_calendar_regs_chk #(.ADDR_W(ADDR_W), .HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timeNow(timeNow), .alarmValue(alarmValue), .halfSecondFlag(halfSecondFlag), .secondTick(secondTick));
